//--- pscmd_defines.vh
// constants for the protection-setting session command interpreter
`ifndef PSCMD_DEFINES_VH
`define PSCMD_DEFINES_VH

// request block word addresses
`define PSCMD_ADDR_REQ_CODE     16'h1f3f
`define PSCMD_ADDR_REQ_COUNT    16'h1f40
`define PSCMD_ADDR_REQ_DEST     16'h1f41
`define PSCMD_ADDR_REQ_SECURITY 16'h1f42
`define PSCMD_ADDR_REQ_PWD_HI   16'h1f43
`define PSCMD_ADDR_REQ_PWD_LO   16'h1f44
`define PSCMD_ADDR_REQ_KEY_HI   16'h1f45
`define PSCMD_ADDR_REQ_KEY_LO   16'h1f46

// response block word addresses
`define PSCMD_ADDR_RSP_CODE     16'h1f53
`define PSCMD_ADDR_RSP_STATUS   16'h1f54
`define PSCMD_ADDR_RSP_BYTES    16'h1f55
`define PSCMD_ADDR_RSP_KEY_HI   16'h1f56
`define PSCMD_ADDR_RSP_KEY_LO   16'h1f57
`define PSCMD_ADDR_RSP_APPLY    16'h1f58

// command codes
`define PSCMD_CODE_OPEN         16'h078a
`define PSCMD_CODE_APPLY        16'h078c
`define PSCMD_CODE_STATUS       16'h0784
`define PSCMD_CODE_CLOSE        16'h078d
`define PSCMD_CODE_SUBMIT_FIRST 16'hc989
`define PSCMD_CODE_SUBMIT_LAST  16'hc98e

// fixed request fields
`define PSCMD_COUNT_OPEN        16'h000a
`define PSCMD_COUNT_SESSION     16'h000e
`define PSCMD_DEST_UNIT         16'h1501
`define PSCMD_SECURITY_TYPE     16'h0001

// returned byte counts
`define PSCMD_BYTES_OPEN        16'h0004
`define PSCMD_BYTES_STATUS      16'h0006
`define PSCMD_BYTES_NONE        16'h0000

// session key limit, largest valid key
`define PSCMD_KEY_MAX           32'hfffffffe

// status codes
`define PSCMD_ERR_NONE          16'h0000
`define PSCMD_ERR_BAD_CODE      16'h0001
`define PSCMD_ERR_BAD_PARAM     16'h0002
`define PSCMD_ERR_PASSWORD      16'h0003
`define PSCMD_ERR_KEY           16'h0004
`define PSCMD_ERR_SEQUENCE      16'h0005
`define PSCMD_ERR_BUSY          16'h0006
`define PSCMD_ERR_LOCKED        16'h0007

// timing
`define PSCMD_CLK_HZ            64'd50000000
`define PSCMD_TIMEOUT_S         64'd300
// five minutes at 50 MHz, sized to the timer width
`define PSCMD_TIMEOUT_CYCLES    36'd15000000000
`define PSCMD_TIMER_W           36
`define PSCMD_APPLY_CYCLES      8'h10

`endif

//--- pscmd_timer.v
// session inactivity timer with restart, stop and one-cycle expiry pulse
`include "pscmd_defines.vh"

module pscmd_timer #(
  parameter [`PSCMD_TIMER_W-1:0] LIMIT = 36'h000000010
) (
  input  wire core_clk_in,
  input  wire rst_b_in,
  input  wire restart_in,
  input  wire stop_in,
  output wire expire_out
);

  reg [`PSCMD_TIMER_W-1:0] count;
  reg                      running;
  reg                      expire;

  assign expire_out = expire;

  // count up while running, fire once at the limit
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count   <= 36'h000000000;
      running <= 1'b0;
      expire  <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (restart_in) begin
        count   <= 36'h000000000;
        running <= 1'b1;
      end else if (stop_in) begin
        running <= 1'b0;
      end else if (running) begin
        if (count >= LIMIT - 36'h000000001) begin
          running <= 1'b0;
          expire  <= 1'b1;
        end else begin
          count <= count + 36'h000000001;
        end
      end
    end
  end

endmodule

//--- pscmd_session.v
// protection-setting session command interpreter with request and response registers
`include "pscmd_defines.vh"

// Behaviour
// RQ1: open needs code 1930 and ten parameters plus destination, security, password.
// RQ2: apply needs code 1932, fourteen parameters, password and session key.
// RQ3: apply status query uses 1924, fourteen parameters, zero password, session key.
// RQ4: close needs code 1933, fourteen parameters, password and session key.
// RQ5: requests carry destination 0x1501 and security type 1.
// RQ6: successful open returns code, status, byte count 4 and new key.
// RQ7: status zero means success; nonzero is a generic error code.
// RQ8: apply status reply returns 6 bytes and echoes the requested key.
// RQ9: apply status word is 1 while apply runs, else 0.
// RQ10: open, apply, close and submits need the administrator password.
// RQ11: submit codes 51593 to 51598 select six protection functions.
// RQ12: session key is 32-bit unsigned, never all ones.
// RQ13: request registers are write-only, response registers read-only.
// RQ14: one session at a time; other interfaces blocked while open.
// RQ15: session times out five minutes after open or unapplied submit.
// RQ16: active settings stay until apply, then switch all at once.
// RQ17: wrong session key gives nonzero status and no change.
module pscmd_session #(
  parameter [`PSCMD_TIMER_W-1:0] TIMEOUT_CYCLES = `PSCMD_TIMEOUT_CYCLES
) (
  input  wire        core_clk_in,
  input  wire        rst_b_in,
  input  wire        reg_wr_en_in,
  input  wire        reg_rd_en_in,
  input  wire [15:0] reg_addr_in,
  input  wire [15:0] reg_wr_data_in,
  input  wire        execute_in,
  input  wire [31:0] admin_password_in,
  output reg  [15:0] reg_rd_data_out,
  output reg         cmd_done_out,
  output wire        session_open_out,
  output wire        external_lock_out,
  output reg         submit_strobe_out,
  output reg  [2:0]  submit_function_out,
  output reg         apply_commit_out,
  output wire        apply_busy_out,
  output wire        session_timeout_out
);

  // one-hot session states
  localparam [3:0] ST_IDLE      = 4'b0001;
  localparam [3:0] ST_OPEN      = 4'b0010;
  localparam [3:0] ST_SUBMITTED = 4'b0100;
  localparam [3:0] ST_APPLYING  = 4'b1000;

  // request block
  reg [15:0] req_code;
  reg [15:0] req_count;
  reg [15:0] req_dest;
  reg [15:0] req_security;
  reg [31:0] req_password;
  reg [31:0] req_key;

  // response block
  reg [15:0] rsp_code;
  reg [15:0] rsp_status;
  reg [15:0] rsp_bytes;
  reg [31:0] rsp_key;
  reg [15:0] rsp_apply;

  reg [3:0]  state;
  reg [31:0] session_key;
  reg [31:0] key_source;
  reg [7:0]  apply_count;

  reg [3:0]  next_state;
  reg [15:0] next_status;
  reg [15:0] next_bytes;
  reg [31:0] next_rsp_key;
  reg [15:0] next_apply;
  reg        next_submit;
  reg        next_apply_start;
  reg        timer_restart;
  reg        timer_stop;

  wire       timeout;
  wire       apply_done;
  wire       is_submit;
  wire       hdr_ok;
  wire       pwd_ok;
  wire       key_ok;
  wire       in_session;
  wire [31:0] fresh_key;
  wire [15:0] submit_index;

  assign in_session          = (state != ST_IDLE);
  assign session_open_out    = in_session;
  // RQ14 block others
  assign external_lock_out   = in_session;
  assign apply_busy_out      = (state == ST_APPLYING);
  assign session_timeout_out = timeout;
  assign apply_done          = (state == ST_APPLYING) && (apply_count == 8'h00);

  // RQ5 destination and security
  assign hdr_ok = (req_dest == `PSCMD_DEST_UNIT) && (req_security == `PSCMD_SECURITY_TYPE);
  // RQ10 administrator password
  assign pwd_ok = (req_password == admin_password_in);
  // RQ17 key must match
  assign key_ok = (req_key == session_key);
  // RQ11 submit code range
  assign is_submit = (req_code >= `PSCMD_CODE_SUBMIT_FIRST) && (req_code <= `PSCMD_CODE_SUBMIT_LAST);
  assign submit_index = req_code - `PSCMD_CODE_SUBMIT_FIRST;
  // RQ12 skip the all-ones key
  assign fresh_key = (key_source > `PSCMD_KEY_MAX) ? 32'h00000000 : key_source;

  pscmd_timer #(
    .LIMIT(TIMEOUT_CYCLES)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .rst_b_in   (rst_b_in),
    .restart_in (timer_restart),
    .stop_in    (timer_stop),
    .expire_out (timeout)
  );

  // RQ13 write-only request registers, writes elsewhere ignored
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_code     <= 16'h0000;
      req_count    <= 16'h0000;
      req_dest     <= 16'h0000;
      req_security <= 16'h0000;
      req_password <= 32'h00000000;
      req_key      <= 32'h00000000;
    end else if (reg_wr_en_in) begin
      case (reg_addr_in)
        `PSCMD_ADDR_REQ_CODE:     req_code <= reg_wr_data_in;
        `PSCMD_ADDR_REQ_COUNT:    req_count <= reg_wr_data_in;
        `PSCMD_ADDR_REQ_DEST:     req_dest <= reg_wr_data_in;
        `PSCMD_ADDR_REQ_SECURITY: req_security <= reg_wr_data_in;
        `PSCMD_ADDR_REQ_PWD_HI:   req_password[31:16] <= reg_wr_data_in;
        `PSCMD_ADDR_REQ_PWD_LO:   req_password[15:0] <= reg_wr_data_in;
        `PSCMD_ADDR_REQ_KEY_HI:   req_key[31:16] <= reg_wr_data_in;
        `PSCMD_ADDR_REQ_KEY_LO:   req_key[15:0] <= reg_wr_data_in;
        default:                  req_code <= req_code;
      endcase
    end
  end

  // RQ13 read-only response registers, others read zero
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rd_data_out <= 16'h0000;
    end else if (reg_rd_en_in) begin
      case (reg_addr_in)
        `PSCMD_ADDR_RSP_CODE:   reg_rd_data_out <= rsp_code;
        `PSCMD_ADDR_RSP_STATUS: reg_rd_data_out <= rsp_status;
        `PSCMD_ADDR_RSP_BYTES:  reg_rd_data_out <= rsp_bytes;
        `PSCMD_ADDR_RSP_KEY_HI: reg_rd_data_out <= rsp_key[31:16];
        `PSCMD_ADDR_RSP_KEY_LO: reg_rd_data_out <= rsp_key[15:0];
        `PSCMD_ADDR_RSP_APPLY:  reg_rd_data_out <= rsp_apply;
        default:                reg_rd_data_out <= 16'h0000;
      endcase
    end
  end

  // command decode and session sequencing
  always @* begin
    next_state       = state;
    next_status      = `PSCMD_ERR_NONE;
    next_bytes       = `PSCMD_BYTES_NONE;
    next_rsp_key     = 32'h00000000;
    next_apply       = 16'h0000;
    next_submit      = 1'b0;
    next_apply_start = 1'b0;
    timer_restart    = 1'b0;
    timer_stop       = 1'b0;
    if (apply_done) begin
      // settings now active, give a fresh window before close
      next_state    = ST_OPEN;
      timer_restart = 1'b1;
    end else if (timeout && (state == ST_OPEN || state == ST_SUBMITTED)) begin
      // RQ15 timeout ends session
      next_state = ST_IDLE;
    end
    if (execute_in) begin
      if (!hdr_ok) begin
        next_status = `PSCMD_ERR_BAD_PARAM;
      end else if (req_code == `PSCMD_CODE_OPEN) begin
        // RQ1 open request
        if (req_count != `PSCMD_COUNT_OPEN) begin
          next_status = `PSCMD_ERR_BAD_PARAM;
        end else if (!pwd_ok) begin
          next_status = `PSCMD_ERR_PASSWORD;
        end else if (in_session) begin
          next_status = `PSCMD_ERR_LOCKED;
        end else begin
          // RQ6 open reply
          next_bytes    = `PSCMD_BYTES_OPEN;
          next_rsp_key  = fresh_key;
          next_state    = ST_OPEN;
          timer_restart = 1'b1;
        end
      end else if (req_code == `PSCMD_CODE_STATUS) begin
        // RQ3 status query
        if (req_count != `PSCMD_COUNT_SESSION || req_password != 32'h00000000) begin
          next_status = `PSCMD_ERR_BAD_PARAM;
        end else if (!in_session || !key_ok) begin
          next_status = `PSCMD_ERR_KEY;
        end else begin
          // RQ8 six bytes, echoed key
          next_bytes   = `PSCMD_BYTES_STATUS;
          next_rsp_key = req_key;
          // RQ9 apply in progress word
          next_apply   = (state == ST_APPLYING && !apply_done) ? 16'h0001 : 16'h0000;
        end
      end else if (req_code == `PSCMD_CODE_APPLY || req_code == `PSCMD_CODE_CLOSE || is_submit) begin
        // RQ2 RQ4 fixed count for apply and close
        if (!is_submit && req_count != `PSCMD_COUNT_SESSION) begin
          next_status = `PSCMD_ERR_BAD_PARAM;
        end else if (!pwd_ok) begin
          next_status = `PSCMD_ERR_PASSWORD;
        end else if (!in_session || !key_ok) begin
          // RQ17 key mismatch, nothing changes
          next_status = `PSCMD_ERR_KEY;
        end else if (state == ST_APPLYING && !apply_done) begin
          next_status = `PSCMD_ERR_BUSY;
        end else if (req_code == `PSCMD_CODE_CLOSE) begin
          // RQ4 close discards any unapplied submit
          next_state = ST_IDLE;
          timer_stop = 1'b1;
        end else if (req_code == `PSCMD_CODE_APPLY) begin
          if (state != ST_SUBMITTED) begin
            next_status = `PSCMD_ERR_SEQUENCE;
          end else begin
            // RQ16 start the one-shot swap
            next_state       = ST_APPLYING;
            next_apply_start = 1'b1;
            timer_stop       = 1'b1;
          end
        end else begin
          // RQ15 submit restarts the window
          next_submit   = 1'b1;
          next_state    = ST_SUBMITTED;
          timer_restart = 1'b1;
        end
      end else begin
        // RQ7 unknown code fails
        next_status = `PSCMD_ERR_BAD_CODE;
      end
    end
  end

  // state, key and apply countdown
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state       <= ST_IDLE;
      session_key <= 32'h00000000;
      key_source  <= 32'h00000000;
      apply_count <= 8'h00;
    end else begin
      key_source <= key_source + 32'h9e3779b9; // free-running key source
      case (next_state)
        ST_IDLE, ST_OPEN, ST_SUBMITTED, ST_APPLYING: state <= next_state;
        default:                                      state <= ST_IDLE;
      endcase
      if (execute_in && req_code == `PSCMD_CODE_OPEN && next_state == ST_OPEN && state == ST_IDLE) begin
        session_key <= fresh_key;
      end
      if (next_apply_start) begin
        apply_count <= `PSCMD_APPLY_CYCLES;
      end else if (state == ST_APPLYING && apply_count != 8'h00) begin
        apply_count <= apply_count - 8'h01;
      end
    end
  end

  // RQ7 response block, done and submit strobes one cycle after execute, commit strobe one cycle after apply ends
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_code            <= 16'h0000;
      rsp_status          <= 16'h0000;
      rsp_bytes           <= 16'h0000;
      rsp_key             <= 32'h00000000;
      rsp_apply           <= 16'h0000;
      cmd_done_out        <= 1'b0;
      submit_strobe_out   <= 1'b0;
      submit_function_out <= 3'h0;
      apply_commit_out    <= 1'b0;
    end else begin
      cmd_done_out      <= execute_in;
      submit_strobe_out <= next_submit;
      // RQ16 commit pulse swaps all settings together
      apply_commit_out  <= apply_done;
      if (next_submit) begin
        submit_function_out <= submit_index[2:0];
      end
      if (execute_in) begin
        rsp_code   <= req_code;
        rsp_status <= next_status;
        rsp_bytes  <= next_bytes;
        rsp_key    <= next_rsp_key;
        rsp_apply  <= next_apply;
      end
    end
  end

endmodule

//--- pscmd_session_monitor.sv
// concurrent checks on the session interpreter ports
`include "pscmd_defines.vh"
module pscmd_monitor #(
  parameter [`PSCMD_TIMER_W-1:0] TIMEOUT_CYCLES = 36'd50
) (
  input wire        core_clk_in,
  input wire        rst_b_in,
  input wire        reg_rd_en_in,
  input wire [15:0] reg_addr_in,
  input wire        execute_in,
  input wire [15:0] reg_rd_data_out,
  input wire        cmd_done_out,
  input wire        session_open_out,
  input wire        external_lock_out,
  input wire        submit_strobe_out,
  input wire [2:0]  submit_function_out,
  input wire        apply_commit_out,
  input wire        apply_busy_out,
  input wire        session_timeout_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_done; cmd_done_out == $past(execute_in); endproperty
  a_done: assert property (p_done) else $error("done pulse not one cycle after execute");
  property p_lock; external_lock_out == session_open_out; endproperty
  a_lock: assert property (p_lock) else $error("lock differs from session state");
  property p_fn; submit_strobe_out |-> submit_function_out <= 3'h5 && session_open_out; endproperty
  a_fn: assert property (p_fn) else $error("bad submit function or no session");
  property p_stb; submit_strobe_out |-> cmd_done_out; endproperty
  a_stb: assert property (p_stb) else $error("submit strobe without command");
  property p_busy; $rose(apply_busy_out) |-> apply_busy_out[*8] ##1 apply_busy_out[*8] ##1 apply_busy_out ##1 !apply_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("apply busy length wrong");
  property p_commit; $fell(apply_busy_out) |-> ##[0:1] (apply_commit_out && !apply_busy_out); endproperty
  a_commit: assert property (p_commit) else $error("no commit when apply ends");
  property p_open; $rose(session_open_out) |-> cmd_done_out; endproperty
  a_open: assert property (p_open) else $error("session opened without command");
  property p_tmo; session_timeout_out |=> !session_open_out; endproperty
  a_tmo: assert property (p_tmo) else $error("session open after timeout");
  property p_unmap; reg_rd_en_in && (reg_addr_in < 16'h1f53 || reg_addr_in > 16'h1f58) |=> reg_rd_data_out == 16'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("nonzero read of non-response word");
  property p_hold; !reg_rd_en_in |=> $stable(reg_rd_data_out); endproperty
  a_hold: assert property (p_hold) else $error("read data changed without read");
  property p_bopen; apply_busy_out |-> session_open_out; endproperty
  a_bopen: assert property (p_bopen) else $error("apply busy outside session");
endmodule
bind pscmd_session pscmd_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_pscmd_monitor (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in),
  .execute_in(execute_in), .reg_rd_data_out(reg_rd_data_out), .cmd_done_out(cmd_done_out),
  .session_open_out(session_open_out), .external_lock_out(external_lock_out),
  .submit_strobe_out(submit_strobe_out), .submit_function_out(submit_function_out),
  .apply_commit_out(apply_commit_out), .apply_busy_out(apply_busy_out),
  .session_timeout_out(session_timeout_out));

//--- pscmd_master.sv
// remote master model writing request blocks and reading responses
module pscmd_master (
  input  logic        core_clk_in,
  output logic        wr_en_out = 1'b0,
  output logic        rd_en_out = 1'b0,
  output logic [15:0] addr_out = 16'h0,
  output logic [15:0] data_out = 16'h0,
  output logic        exec_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // one bus cycle; released enables drop low, address and data show the inverse of the last value
  task automatic cyc(input logic w, r, e, input logic [15:0] a, d);
    @(posedge core_clk_in);
    #1;
    {wr_en_out, rd_en_out, exec_out} = {w, r, e};
    addr_out = a;
    data_out = d;
    @(posedge core_clk_in);
    #1;
    {wr_en_out, rd_en_out, exec_out} = 3'h0;
    addr_out = ~a;
    data_out = ~d;
  endtask
  // fixed security, key high word first
  task automatic send(input logic [15:0] c, n, ds, input logic [31:0] p, k);
    logic [15:0] v [8];
    v = '{c, n, ds, 16'h0001, p[31:16], p[15:0], k[31:16], k[15:0]};
    for (int i = 0; i < 8; i++) cyc(1'b1, 1'b0, 1'b0, 16'h1f3f + 16'(i), v[i]);
    cyc(1'b0, 1'b0, 1'b1, 16'h0, 16'h0);
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the session command interpreter
`include "pscmd_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [15:0] v; logic [15:0] m;} pscmd_note_t;
  // longest gap without a timer restart in the sequence below, apart from the final wait past TMO, is about 150 cycles
  localparam int TMO = 200;
  logic clk = 1'b0, rst_b = 1'b0, wr, rd, ex, sstb, rd_seen = 1'b0;
  logic [15:0] addr, wd, rdata;
  logic [2:0] sfn;
  logic [31:0] pwd = 32'h0, rng = 32'd63, key, got;
  int miscompares = 0, n_checks = 0;
  pscmd_note_t q[$];
  logic [2:0] fq[$];
  always #10 clk = ~clk;
  pscmd_master i_pscmd_master (.core_clk_in(clk), .wr_en_out(wr), .rd_en_out(rd), .addr_out(addr),
    .data_out(wd), .exec_out(ex));
  pscmd_session #(.TIMEOUT_CYCLES(36'(TMO))) i_pscmd_session (.core_clk_in(clk), .rst_b_in(rst_b),
    .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(addr), .reg_wr_data_in(wd), .execute_in(ex),
    .admin_password_in(pwd), .reg_rd_data_out(rdata), .cmd_done_out(), .session_open_out(),
    .external_lock_out(), .submit_strobe_out(sstb), .submit_function_out(sfn), .apply_commit_out(),
    .apply_busy_out(), .session_timeout_out());
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic cmp_word(input pscmd_note_t n, input logic [15:0] s);
    n_checks++;
    if ((s & n.m) !== (n.v & n.m)) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n.nm, n.v, s);
    end
  endtask
  task automatic cmp_fn(input logic [2:0] e, input logic [2:0] s);
    cmp_word('{"submit function", {13'h0, e}, 16'h0007}, {13'h0, s});
  endtask
  // watchers take the oldest note whenever a result shows
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) if (rd_seen) cmp_word(q.pop_front(), rdata);
  always @(negedge clk) if (sstb) cmp_fn(fq.pop_front(), sfn);
  task automatic chk_rd(input string nm, input logic [15:0] a, e, m = 16'hffff);
    q.push_back('{nm, e, m});
    i_pscmd_master.cyc(1'b0, 1'b1, 1'b0, a, 16'h0);
  endtask
  task automatic cmd(input logic [15:0] c, n, input logic [31:0] p, k);
    i_pscmd_master.send(c, n, `PSCMD_DEST_UNIT, p, k);
  endtask
  // check the whole response block, keeping the key seen
  task automatic rsp(input logic [15:0] c, st, by, ap, input logic [31:0] k, input logic [15:0] km = 16'hffff);
    chk_rd("last code", `PSCMD_ADDR_RSP_CODE, c);
    chk_rd("status", `PSCMD_ADDR_RSP_STATUS, st);
    chk_rd("byte count", `PSCMD_ADDR_RSP_BYTES, by);
    chk_rd("key hi", `PSCMD_ADDR_RSP_KEY_HI, k[31:16], km);
    got[31:16] = rdata;
    chk_rd("key lo", `PSCMD_ADDR_RSP_KEY_LO, k[15:0], km);
    got[15:0] = rdata;
    chk_rd("apply flag", `PSCMD_ADDR_RSP_APPLY, ap);
  endtask
  task automatic fail(input logic [15:0] c, st);
    rsp(c, st, 16'h0, 16'h0, 32'h0);
  endtask
  task automatic test_done;
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    #100us;
    miscompares++;
    test_done();
  end
  // main sequence
  initial begin
    rng = xs(rng);
    pwd = rng;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    fail(16'h0, 16'h0);
    cmd(`PSCMD_CODE_SUBMIT_LAST + 16'h0001, 16'h001a, pwd, 32'h0);
    fail(`PSCMD_CODE_SUBMIT_LAST + 16'h0001, `PSCMD_ERR_BAD_CODE);
    cmd(`PSCMD_CODE_OPEN, `PSCMD_COUNT_OPEN, ~pwd, 32'h0);
    fail(`PSCMD_CODE_OPEN, `PSCMD_ERR_PASSWORD);
    cmd(`PSCMD_CODE_OPEN, `PSCMD_COUNT_SESSION, pwd, 32'h0);
    fail(`PSCMD_CODE_OPEN, `PSCMD_ERR_BAD_PARAM);
    i_pscmd_master.send(`PSCMD_CODE_OPEN, `PSCMD_COUNT_OPEN, 16'h1500, pwd, 32'h0);
    fail(`PSCMD_CODE_OPEN, `PSCMD_ERR_BAD_PARAM);
    chk_rd("request word", `PSCMD_ADDR_REQ_CODE, 16'h0);
    chk_rd("unmapped", 16'h1f59 + {8'h0, rng[7:0]}, 16'h0);
    cmd(`PSCMD_CODE_STATUS, `PSCMD_COUNT_SESSION, 32'h0, 32'h0);
    fail(`PSCMD_CODE_STATUS, `PSCMD_ERR_KEY);
    cmd(`PSCMD_CODE_OPEN, `PSCMD_COUNT_OPEN, pwd, 32'h0);
    rsp(`PSCMD_CODE_OPEN, `PSCMD_ERR_NONE, `PSCMD_BYTES_OPEN, 16'h0, 32'h0, 16'h0);
    key = got;
    cmd(`PSCMD_CODE_OPEN, `PSCMD_COUNT_OPEN, pwd, 32'h0);
    fail(`PSCMD_CODE_OPEN, `PSCMD_ERR_LOCKED);
    cmd(`PSCMD_CODE_APPLY, `PSCMD_COUNT_SESSION, pwd, key);
    fail(`PSCMD_CODE_APPLY, `PSCMD_ERR_SEQUENCE);
    cmd(`PSCMD_CODE_CLOSE, `PSCMD_COUNT_SESSION, pwd, key ^ rng);
    fail(`PSCMD_CODE_CLOSE, `PSCMD_ERR_KEY);
    cmd(`PSCMD_CODE_SUBMIT_FIRST, 16'h001a, ~pwd, key);
    fail(`PSCMD_CODE_SUBMIT_FIRST, `PSCMD_ERR_PASSWORD);
    for (int i = 0; i < 6; i++) begin
      fq.push_back(3'(i));
      cmd(`PSCMD_CODE_SUBMIT_FIRST + 16'(i), 16'h001a, pwd, key);
      chk_rd("status", `PSCMD_ADDR_RSP_STATUS, `PSCMD_ERR_NONE);
    end
    cmd(`PSCMD_CODE_APPLY, `PSCMD_COUNT_SESSION, pwd, key);
    i_pscmd_master.cyc(1'b0, 1'b0, 1'b1, 16'h0, 16'h0);
    chk_rd("status", `PSCMD_ADDR_RSP_STATUS, `PSCMD_ERR_BUSY);
    i_pscmd_master.cyc(1'b1, 1'b0, 1'b0, `PSCMD_ADDR_REQ_CODE, `PSCMD_CODE_STATUS);
    i_pscmd_master.cyc(1'b1, 1'b0, 1'b0, `PSCMD_ADDR_REQ_PWD_HI, 16'h0);
    i_pscmd_master.cyc(1'b1, 1'b0, 1'b0, `PSCMD_ADDR_REQ_PWD_LO, 16'h0);
    i_pscmd_master.cyc(1'b0, 1'b0, 1'b1, 16'h0, 16'h0);
    rsp(`PSCMD_CODE_STATUS, `PSCMD_ERR_NONE, `PSCMD_BYTES_STATUS, 16'h1, key);
    repeat (20) @(posedge clk);
    i_pscmd_master.cyc(1'b0, 1'b0, 1'b1, 16'h0, 16'h0);
    rsp(`PSCMD_CODE_STATUS, `PSCMD_ERR_NONE, `PSCMD_BYTES_STATUS, 16'h0, key);
    cmd(`PSCMD_CODE_STATUS, `PSCMD_COUNT_SESSION, pwd, key);
    fail(`PSCMD_CODE_STATUS, `PSCMD_ERR_BAD_PARAM);
    cmd(`PSCMD_CODE_CLOSE, `PSCMD_COUNT_SESSION, pwd, key);
    chk_rd("status", `PSCMD_ADDR_RSP_STATUS, `PSCMD_ERR_NONE);
    cmd(`PSCMD_CODE_CLOSE, `PSCMD_COUNT_SESSION, pwd, key);
    fail(`PSCMD_CODE_CLOSE, `PSCMD_ERR_KEY);
    cmd(`PSCMD_CODE_OPEN, `PSCMD_COUNT_OPEN, pwd, 32'h0);
    rsp(`PSCMD_CODE_OPEN, `PSCMD_ERR_NONE, `PSCMD_BYTES_OPEN, 16'h0, 32'h0, 16'h0);
    key = got;
    repeat (TMO + 10) @(posedge clk);
    cmd(`PSCMD_CODE_STATUS, `PSCMD_COUNT_SESSION, 32'h0, key);
    fail(`PSCMD_CODE_STATUS, `PSCMD_ERR_KEY);
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule
